//--- core/address_pin_gpio_mux.sv
// Shared-pin mux for the upper address lines and GPIO ports A and B
// Operation
// - Idle-bus float of address and control pins depends on bus_drive_control.
// - Port A shared pins come out of reset in the address function.
// - Where the address function is not bonded, port A runs as GPIO only.
// - Each port A line has its own direction bit.
// - Clearing port A pull-up bit n turns off the pull-up on line n.
// - Port B lines sharing address 16 to 19 default to GPIO after reset.
// - Clearing port B pull-up bit n turns off the pull-up on line n.
// - Each port B line in GPIO function is programmable input or output.
// - Clearing a peripheral enable bit hands the pin to the other function.
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
module address_pin_gpio_mux
  import pin_mux_pkg::*;
#(
  parameter bit PORT_A_ADDR_BONDED = 1'b1
) (
  input  wire logic                                SYS_CLK,
  input  wire logic                                RST_N,
  input  wire logic                                CLK_EN,
  input  wire logic [pin_mux_pkg::ADDR_W-1:0]      S_AXI_AWADDR,
  input  wire logic                                S_AXI_AWVALID,
  output      logic                                S_AXI_AWREADY,
  input  wire logic [31:0]                         S_AXI_WDATA,
  input  wire logic [3:0]                          S_AXI_WSTRB,
  input  wire logic                                S_AXI_WVALID,
  output      logic                                S_AXI_WREADY,
  output      logic [1:0]                          S_AXI_BRESP,
  output      logic                                S_AXI_BVALID,
  input  wire logic                                S_AXI_BREADY,
  input  wire logic [pin_mux_pkg::ADDR_W-1:0]      S_AXI_ARADDR,
  input  wire logic                                S_AXI_ARVALID,
  output      logic                                S_AXI_ARREADY,
  output      logic [31:0]                         S_AXI_RDATA,
  output      logic [1:0]                          S_AXI_RRESP,
  output      logic                                S_AXI_RVALID,
  input  wire logic                                S_AXI_RREADY,
  input  wire logic                                EXT_BUS_ACTIVE,
  input  wire logic [pin_mux_pkg::PORT_A_LINES-1:0] EXT_ADDR_LOW,
  input  wire logic [pin_mux_pkg::PORT_B_LINES-1:0] EXT_ADDR_HIGH,
  output      logic                                EXT_CTRL_OE,
  input  wire logic [pin_mux_pkg::PORT_A_LINES-1:0] GPIO_A_DOUT,
  input  wire logic [pin_mux_pkg::PORT_B_LINES-1:0] GPIO_B_DOUT,
  output      logic [pin_mux_pkg::PORT_A_LINES-1:0] GPIO_A_DIN,
  output      logic [pin_mux_pkg::PORT_B_LINES-1:0] GPIO_B_DIN,
  input  wire logic [pin_mux_pkg::PORT_A_LINES-1:0] PIN_A_I,
  output      logic [pin_mux_pkg::PORT_A_LINES-1:0] PIN_A_O,
  output      logic [pin_mux_pkg::PORT_A_LINES-1:0] PIN_A_OE,
  output      logic [pin_mux_pkg::PORT_A_LINES-1:0] PIN_A_PU,
  input  wire logic [pin_mux_pkg::PORT_B_LINES-1:0] PIN_B_I,
  output      logic [pin_mux_pkg::PORT_B_LINES-1:0] PIN_B_O,
  output      logic [pin_mux_pkg::PORT_B_LINES-1:0] PIN_B_OE,
  output      logic [pin_mux_pkg::PORT_B_LINES-1:0] PIN_B_PU
);
  import pin_mux_pkg::*;
  //////////////////////////////////////////////////////////////////////////
  // Register bus slave
  logic [ADDR_W-1:0]       aw_addr;
  logic                    aw_full;
  logic [31:0]             w_data;
  logic                    w_lane0;
  logic                    w_full;
  logic                    bvalid;
  logic [1:0]              bresp;
  logic                    rvalid;
  logic [1:0]              rresp;
  logic [31:0]             rdata;
  logic [ADDR_W-1:0]       next_aw_addr;
  logic                    next_aw_full;
  logic [31:0]             next_w_data;
  logic                    next_w_lane0;
  logic                    next_w_full;
  logic                    next_bvalid;
  logic [1:0]              next_bresp;
  logic                    next_rvalid;
  logic [1:0]              next_rresp;
  logic [31:0]             next_rdata;
  logic                    do_write;
  logic                    hit;
  logic                    bus_drive_control;
  logic [PORT_A_LINES-1:0] a_periph;
  logic [PORT_A_LINES-1:0] a_dir;
  logic [PORT_A_LINES-1:0] a_pullup;
  logic [PORT_B_LINES-1:0] b_periph;
  logic [PORT_B_LINES-1:0] b_dir;
  logic [PORT_B_LINES-1:0] b_pullup;
  logic                    next_bus_drive_control;
  logic [PORT_A_LINES-1:0] next_a_periph;
  logic [PORT_A_LINES-1:0] next_a_dir;
  logic [PORT_A_LINES-1:0] next_a_pullup;
  logic [PORT_B_LINES-1:0] next_b_periph;
  logic [PORT_B_LINES-1:0] next_b_dir;
  logic [PORT_B_LINES-1:0] next_b_pullup;
  // Handshakes drop while frozen, so no beat is lost with CLK_EN low
  assign S_AXI_AWREADY = CLK_EN && !aw_full && !bvalid;
  assign S_AXI_WREADY  = CLK_EN && !w_full && !bvalid;
  assign S_AXI_BVALID  = CLK_EN && bvalid;
  assign S_AXI_BRESP   = bresp;
  assign S_AXI_ARREADY = CLK_EN && !rvalid;
  assign S_AXI_RVALID  = CLK_EN && rvalid;
  assign S_AXI_RRESP   = rresp;
  assign S_AXI_RDATA   = rdata;
  assign do_write      = aw_full && w_full && !bvalid;
  // Address and data may arrive in either order; each is parked until both
  // are present, and the pair is retired the cycle after the second lands.
  always_comb begin
    next_aw_addr = aw_addr;
    next_aw_full = aw_full;
    next_w_data  = w_data;
    next_w_lane0 = w_lane0;
    next_w_full  = w_full;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_aw_addr = S_AXI_AWADDR;
      next_aw_full = 1'b1;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_w_data  = S_AXI_WDATA;
      next_w_lane0 = S_AXI_WSTRB[0];
      next_w_full  = 1'b1;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && S_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end
  end
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_addr <= '0;
      aw_full <= 1'b0;
      w_data  <= '0;
      w_lane0 <= 1'b0;
      w_full  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else if (CLK_EN) begin
      aw_addr <= next_aw_addr;
      aw_full <= next_aw_full;
      w_data  <= next_w_data;
      w_lane0 <= next_w_lane0;
      w_full  <= next_w_full;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Control registers; all fields sit in byte lane 0
  always_comb begin
    next_bus_drive_control = bus_drive_control;
    next_a_periph = a_periph;
    next_a_dir    = a_dir;
    next_a_pullup = a_pullup;
    next_b_periph = b_periph;
    next_b_dir    = b_dir;
    next_b_pullup = b_pullup;
    hit           = 1'b1;
    case (aw_addr)
      OFS_BUS_CTRL:  if (do_write && w_lane0) begin
        next_bus_drive_control = w_data[BUS_DRIVE_BIT];
      end
      OFS_A_PERIPH:  if (do_write && w_lane0) begin
        next_a_periph = w_data[PORT_A_LINES-1:0];
      end
      OFS_A_DIR:     if (do_write && w_lane0) begin
        next_a_dir = w_data[PORT_A_LINES-1:0];
      end
      OFS_A_PULLUP:  if (do_write && w_lane0) begin
        next_a_pullup = w_data[PORT_A_LINES-1:0];
      end
      OFS_B_PERIPH:  if (do_write && w_lane0) begin
        next_b_periph = w_data[PORT_B_LINES-1:0];
      end
      OFS_B_DIR:     if (do_write && w_lane0) begin
        next_b_dir = w_data[PORT_B_LINES-1:0];
      end
      OFS_B_PULLUP:  if (do_write && w_lane0) begin
        next_b_pullup = w_data[PORT_B_LINES-1:0];
      end
      default:       hit = 1'b0;
    endcase
  end
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_drive_control <= RST_BUS_DRIVE;
      a_periph <= RST_A_PERIPH;
      a_dir    <= RST_A_DIR;
      a_pullup <= RST_A_PULLUP;
      b_periph <= RST_B_PERIPH;
      b_dir    <= RST_B_DIR;
      b_pullup <= RST_B_PULLUP;
    end else if (CLK_EN) begin
      bus_drive_control <= next_bus_drive_control;
      a_periph <= next_a_periph;
      a_dir    <= next_a_dir;
      a_pullup <= next_a_pullup;
      b_periph <= next_b_periph;
      b_dir    <= next_b_dir;
      b_pullup <= next_b_pullup;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Read channel
  always_comb begin
    next_rvalid = rvalid;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = '0;
      case (S_AXI_ARADDR)
        OFS_BUS_CTRL:  next_rdata[BUS_DRIVE_BIT] = bus_drive_control;
        OFS_A_PERIPH:  next_rdata[PORT_A_LINES-1:0] = a_periph;
        OFS_A_DIR:     next_rdata[PORT_A_LINES-1:0] = a_dir;
        OFS_A_PULLUP:  next_rdata[PORT_A_LINES-1:0] = a_pullup;
        OFS_B_PERIPH:  next_rdata[PORT_B_LINES-1:0] = b_periph;
        OFS_B_DIR:     next_rdata[PORT_B_LINES-1:0] = b_dir;
        OFS_B_PULLUP:  next_rdata[PORT_B_LINES-1:0] = b_pullup;
        OFS_PIN_STATE: begin
          next_rdata[PORT_A_LINES-1:0] = GPIO_A_DIN;
          next_rdata[PIN_B_SHIFT +: PORT_B_LINES] = GPIO_B_DIN;
        end
        default:       next_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid && S_AXI_RREADY) begin
      next_rvalid = 1'b0;
    end
  end
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid <= 1'b0;
      rresp  <= RESP_OKAY;
      rdata  <= '0;
    end else if (CLK_EN) begin
      rvalid <= next_rvalid;
      rresp  <= next_rresp;
      rdata  <= next_rdata;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Pin mux; pad drive is registered so pins never see decode glitches
  logic                    addr_oe;
  logic [PORT_A_LINES-1:0] a_is_addr;
  logic [PORT_B_LINES-1:0] b_is_addr;
  logic [PORT_A_LINES-1:0] next_pa_o;
  logic [PORT_A_LINES-1:0] next_pa_oe;
  logic [PORT_B_LINES-1:0] next_pb_o;
  logic [PORT_B_LINES-1:0] next_pb_oe;
  logic                    next_ctrl_oe;
  // Address drivers float on an idle bus only while drive-control is clear
  assign addr_oe = EXT_BUS_ACTIVE || bus_drive_control;
  // An unbonded address function leaves port A as plain GPIO
  assign a_is_addr = PORT_A_ADDR_BONDED ? ~a_periph : '0;
  assign b_is_addr = ~b_periph;
  always_comb begin
    next_ctrl_oe = addr_oe;
    next_pa_o    = '0;
    next_pa_oe   = '0;
    next_pb_o    = '0;
    next_pb_oe   = '0;
    for (int i = 0; i < PORT_A_LINES; i++) begin
      next_pa_o[i]  = a_is_addr[i] ? EXT_ADDR_LOW[i] : GPIO_A_DOUT[i];
      next_pa_oe[i] = a_is_addr[i] ? addr_oe : a_dir[i];
    end
    for (int i = 0; i < PORT_B_LINES; i++) begin
      next_pb_o[i]  = b_is_addr[i] ? EXT_ADDR_HIGH[i] : GPIO_B_DOUT[i];
      next_pb_oe[i] = b_is_addr[i] ? addr_oe : b_dir[i];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PIN_A_O     <= '0;
      PIN_A_OE    <= '0;
      PIN_A_PU    <= RST_A_PULLUP;
      PIN_B_O     <= '0;
      PIN_B_OE    <= '0;
      PIN_B_PU    <= RST_B_PULLUP;
      EXT_CTRL_OE <= 1'b0;
      GPIO_A_DIN  <= '0;
      GPIO_B_DIN  <= '0;
    end else if (CLK_EN) begin
      PIN_A_O     <= next_pa_o;
      PIN_A_OE    <= next_pa_oe;
      PIN_A_PU    <= a_pullup;
      PIN_B_O     <= next_pb_o;
      PIN_B_OE    <= next_pb_oe;
      PIN_B_PU    <= b_pullup;
      EXT_CTRL_OE <= next_ctrl_oe;
      GPIO_A_DIN  <= PIN_A_I;
      GPIO_B_DIN  <= PIN_B_I;
    end
  end
endmodule

//--- core/pin_mux_pkg.sv
// Package: register map, field layout, reset values and pin counts of the mux
package pin_mux_pkg;
  localparam int          PORT_A_LINES   = 6;
  localparam int          PORT_B_LINES   = 4;
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  OFS_BUS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_A_PERIPH   = 8'h04;
  localparam logic [7:0]  OFS_A_DIR      = 8'h08;
  localparam logic [7:0]  OFS_A_PULLUP   = 8'h0C;
  localparam logic [7:0]  OFS_B_PERIPH   = 8'h10;
  localparam logic [7:0]  OFS_B_DIR      = 8'h14;
  localparam logic [7:0]  OFS_B_PULLUP   = 8'h18;
  localparam logic [7:0]  OFS_PIN_STATE  = 8'h1C;
  localparam int          BUS_DRIVE_BIT  = 0;
  localparam int          PIN_B_SHIFT    = 8;
  localparam logic        RST_BUS_DRIVE  = 1'b0;
  localparam logic [5:0]  RST_A_PERIPH   = 6'h00;
  localparam logic [5:0]  RST_A_DIR      = 6'h00;
  localparam logic [5:0]  RST_A_PULLUP   = 6'h3F;
  localparam logic [3:0]  RST_B_PERIPH   = 4'hF;
  localparam logic [3:0]  RST_B_DIR      = 4'h0;
  localparam logic [3:0]  RST_B_PULLUP   = 4'hF;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

//--- verification/pin_mux_monitor.sv
// Checker tying pin enables and pull-ups to a shadow of the registers
module pin_mux_monitor
  import pin_mux_pkg::*;
#(
  parameter bit BONDED = 1'b1
) (
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        CLK_EN,
  input wire logic [7:0]  S_AXI_AWADDR,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0]  S_AXI_WSTRB,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        EXT_BUS_ACTIVE,
  input wire logic        EXT_CTRL_OE,
  input wire logic [5:0]  PIN_A_OE,
  input wire logic [5:0]  PIN_A_PU,
  input wire logic [3:0]  PIN_B_OE,
  input wire logic [3:0]  PIN_B_PU
);
  logic       live;
  logic       pend;
  logic [7:0] adr;
  logic [5:0] dat;
  logic [5:0] regs [7];
  // Shadow expects address and data taken at one edge, as the bench offers
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      live <= 1'b0;
      pend <= 1'b0;
      regs <= '{6'(RST_BUS_DRIVE), RST_A_PERIPH, RST_A_DIR, RST_A_PULLUP,
                6'(RST_B_PERIPH), 6'(RST_B_DIR), 6'(RST_B_PULLUP)};
    end else begin
      live <= CLK_EN;
      if (CLK_EN) begin
        pend <= S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
                && S_AXI_WREADY && S_AXI_WSTRB[0];
        adr  <= S_AXI_AWADDR;
        dat  <= S_AXI_WDATA[5:0];
        if (pend && adr[7:5] == 3'h0 && adr[4:2] != 3'h7 && adr[1:0] == 2'h0)
          regs[adr[4:2]] <= dat;
      end
    end
  end
  wire       drive = EXT_BUS_ACTIVE | regs[0][0];
  wire [5:0] a_oe  = BONDED ? (regs[1] & regs[2]) | (~regs[1] & {6{drive}})
                            : regs[2];
  wire [3:0] b_oe  = (regs[4][3:0] & regs[5][3:0])
                     | (~regs[4][3:0] & {4{drive}});
  wire [5:0] a_pu  = regs[3];
  wire [3:0] b_pu  = regs[6][3:0];
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////
  property p_ctrl_oe;
    live |-> EXT_CTRL_OE == $past(drive);
  endproperty
  a_ctrl_oe: assert property (p_ctrl_oe) else $error("ctrl enable");
  property p_a_oe;
    live |-> PIN_A_OE == $past(a_oe);
  endproperty
  a_a_oe: assert property (p_a_oe) else $error("A enable");
  property p_b_oe;
    live |-> PIN_B_OE == $past(b_oe);
  endproperty
  a_b_oe: assert property (p_b_oe) else $error("port B enable");
  property p_a_pu;
    live |-> PIN_A_PU == $past(a_pu);
  endproperty
  a_a_pu: assert property (p_a_pu) else $error("port A pull-up");
  property p_b_pu;
    live |-> PIN_B_PU == $past(b_pu);
  endproperty
  a_b_pu: assert property (p_b_pu) else $error("port B pull-up");
  property p_rst_addr;
    $rose(RST_N) && CLK_EN |=>
      PIN_A_OE == (BONDED ? {6{$past(EXT_BUS_ACTIVE)}} : 6'h00);
  endproperty
  a_rst_addr: assert property (p_rst_addr) else $error("A reset fn");
  property p_rst_gpio;
    $rose(RST_N) && CLK_EN |=> PIN_B_OE == 4'h0;
  endproperty
  a_rst_gpio: assert property (p_rst_gpio) else $error("B reset fn");
  property p_rst_pu;
    $rose(RST_N) |-> PIN_A_PU == 6'h3F && PIN_B_PU == 4'hF;
  endproperty
  a_rst_pu: assert property (p_rst_pu) else $error("reset pull");
endmodule
bind address_pin_gpio_mux pin_mux_monitor #(.BONDED(PORT_A_ADDR_BONDED))
  pin_mux_monitor_inst (.*);

//--- verification/pin_side_model.sv
// Board side of the shared pins: pull-ups, outside drivers
module pin_side_model #(
  parameter int N = 6
) (
  input  wire logic         clk,
  input  wire logic [N-1:0] pin_o,
  input  wire logic [N-1:0] pin_oe,
  input  wire logic [N-1:0] pin_pu,
  input  wire logic         drive_en,
  input  wire logic [N-1:0] drive_val,
  output      logic [N-1:0] pin_i
);
  // A floating line toggles so that no settled value is trusted
  logic [N-1:0] churn = {N{1'b0}};
  always @(posedge clk) churn <= ~churn;
  assign pin_i = (pin_oe & pin_o)
                 | (~pin_oe & (drive_en ? drive_val : (pin_pu | churn)));
endmodule

//--- verification/tb.sv
// Self-checking bench for the shared address and GPIO pin mux
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pin_mux_pkg::*;
  localparam logic [7:0] OFS [7] = '{OFS_BUS_CTRL, OFS_A_PERIPH, OFS_A_DIR,
    OFS_A_PULLUP, OFS_B_PERIPH, OFS_B_DIR, OFS_B_PULLUP};
  localparam logic [31:0] RSTV [7] = '{32'(RST_BUS_DRIVE), 32'(RST_A_PERIPH),
    32'(RST_A_DIR), 32'(RST_A_PULLUP), 32'(RST_B_PERIPH), 32'(RST_B_DIR),
    32'(RST_B_PULLUP)};
  logic SYS_CLK = 1'b0, RST_N = 1'b0, CLK_EN = 1'b1, EXT_BUS_ACTIVE = 1'b1;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, den = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY, S_AXI_BVALID;
  logic S_AXI_RVALID, EXT_CTRL_OE;
  logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic [5:0]  EXT_ADDR_LOW = 6'h00, GPIO_A_DOUT = 6'h00, adv = 6'h00;
  logic [5:0]  GPIO_A_DIN, PIN_A_I, PIN_A_O, PIN_A_OE, PIN_A_PU;
  logic [3:0]  EXT_ADDR_HIGH = 4'h0, GPIO_B_DOUT = 4'h0, bdv = 4'h0;
  logic [3:0]  GPIO_B_DIN, PIN_B_I, PIN_B_O, PIN_B_OE, PIN_B_PU;
  logic [5:0]  ga_o, ga_oe;
  int          mismatches = 0, checks = 0, cyc = 0;
  logic [33:0] exp_q [$];
  address_pin_gpio_mux address_pin_gpio_mux_inst (.*);
  // Second copy built without the address function on port A
  address_pin_gpio_mux #(.PORT_A_ADDR_BONDED(1'b0)) gpio_only_inst (
    .SYS_CLK, .RST_N, .CLK_EN, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY(), .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
    .S_AXI_WREADY(), .S_AXI_BRESP(), .S_AXI_BVALID(), .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY(), .S_AXI_RDATA(),
    .S_AXI_RRESP(), .S_AXI_RVALID(), .S_AXI_RREADY, .EXT_BUS_ACTIVE,
    .EXT_ADDR_LOW, .EXT_ADDR_HIGH, .EXT_CTRL_OE(), .GPIO_A_DOUT,
    .GPIO_B_DOUT, .GPIO_A_DIN(), .GPIO_B_DIN(), .PIN_A_I, .PIN_A_O(ga_o),
    .PIN_A_OE(ga_oe), .PIN_A_PU(), .PIN_B_I, .PIN_B_O(), .PIN_B_OE(),
    .PIN_B_PU());
  pin_side_model #(.N(6)) pin_side_model_a_inst (.clk(SYS_CLK),
    .pin_o(PIN_A_O), .pin_oe(PIN_A_OE), .pin_pu(PIN_A_PU), .drive_en(den),
    .drive_val(adv), .pin_i(PIN_A_I));
  pin_side_model #(.N(4)) pin_side_model_b_inst (.clk(SYS_CLK),
    .pin_o(PIN_B_O), .pin_oe(PIN_B_OE), .pin_pu(PIN_B_PU), .drive_en(den),
    .drive_val(bdv), .pin_i(PIN_B_I));
  always #20 SYS_CLK = ~SYS_CLK;
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic pins(input logic [5:0] aoe, ao, apu,
                      input logic [3:0] boe, bo, bpu, input logic c);
    chk(34'({EXT_CTRL_OE, PIN_A_OE, PIN_A_O, PIN_A_PU, PIN_B_OE, PIN_B_O,
        PIN_B_PU}), 34'({c, aoe, ao, apu, boe, bo, bpu}));
  endtask
  // Each channel drops its valid at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    while (aw || w) begin
      @(posedge SYS_CLK);
      if (S_AXI_AWREADY === 1'b1) aw = 1'b0;
      if (S_AXI_WREADY === 1'b1) w = 1'b0;
      S_AXI_AWVALID <= aw;
      S_AXI_WVALID <= w;
    end
    do @(posedge SYS_CLK); while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    chk({S_AXI_BRESP, 32'h0}, {r, 32'h0});
    @(posedge SYS_CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do @(posedge SYS_CLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge SYS_CLK); while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  always @(posedge SYS_CLK)
    if (S_AXI_RVALID === 1'b1 && S_AXI_RREADY === 1'b1)
      chk({S_AXI_RRESP, S_AXI_RDATA},
          exp_q.size() > 0 ? exp_q.pop_front() : {34{1'bx}});
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [63:0] r;
    logic [31:0] wv [7];
    logic [5:0]  aoe, ao;
    logic [3:0]  boe, bo;
    logic        dr;
    void'($urandom(64));
    repeat (16) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    pins(6'h3F, 6'h00, 6'h3F, 4'h0, 4'h0, 4'hF, 1'b1);
    chk(34'({ga_oe, ga_o}), 34'({6'h00, 6'h00}));
    foreach (OFS[i]) rd(OFS[i], {RESP_OKAY, RSTV[i]});
    repeat (8) begin
      r = {$urandom, $urandom};
      {bdv, adv, GPIO_B_DOUT, GPIO_A_DOUT, EXT_ADDR_HIGH, EXT_ADDR_LOW}
        <= r[61:32];
      EXT_BUS_ACTIVE <= r[31];
      den <= 1'b1;
      wv = '{32'(r[30]), 32'(r[5:0]), 32'(r[11:6]), 32'(r[17:12]),
             32'(r[21:18]), 32'(r[25:22]), 32'(r[29:26])};
      foreach (OFS[i]) wr(OFS[i], wv[i], RESP_OKAY);
      dr = r[31] | r[30];
      aoe = (r[5:0] & r[11:6]) | (~r[5:0] & {6{dr}});
      ao = (r[5:0] & r[47:42]) | (~r[5:0] & r[37:32]);
      boe = (r[21:18] & r[25:22]) | (~r[21:18] & {4{dr}});
      bo = (r[21:18] & r[51:48]) | (~r[21:18] & r[41:38]);
      pins(aoe, ao, r[17:12], boe, bo, r[29:26], dr);
      chk(34'({ga_oe, ga_o}), 34'({r[11:6], r[47:42]}));
      foreach (OFS[i]) rd(OFS[i], {RESP_OKAY, wv[i]});
      rd(OFS_PIN_STATE, {RESP_OKAY, 20'h0, (boe & bo) | (~boe & r[61:58]),
         2'h0, (aoe & ao) | (~aoe & r[57:52])});
    end
    // A write without byte lane 0 is answered but changes nothing
    S_AXI_WSTRB <= 4'hE;
    wr(OFS_A_DIR, 32'h0000003F, RESP_OKAY);
    S_AXI_WSTRB <= 4'hF;
    rd(OFS_A_DIR, {RESP_OKAY, wv[2]});
    // Pins hold while the clock enable is low, then follow the new inputs
    CLK_EN <= 1'b0;
    {GPIO_A_DOUT, EXT_ADDR_LOW} <= ~{GPIO_A_DOUT, EXT_ADDR_LOW};
    repeat (3) @(posedge SYS_CLK);
    pins(aoe, ao, r[17:12], boe, bo, r[29:26], dr);
    CLK_EN <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    pins(aoe, ~ao, r[17:12], boe, bo, r[29:26], dr);
    wr(8'h20, 32'hFFFFFFFF, RESP_SLVERR);
    rd(8'h20, {RESP_SLVERR, 32'h0});
    results();
  end
endmodule
